// *** shared/pmls_pkg.sv ***
// Package of command codes, reset values and field positions for the limit and status bank
package pmls_pkg;
  localparam logic [6:0]  DEV_ADDR       = 7'h40;    // Bus address of this device
  localparam logic [7:0]  CMD_CLEAR      = 8'h03;    // Clear all latched flags
  localparam logic [7:0]  CMD_FEATURE    = 8'h19;    // Feature report
  localparam logic [7:0]  CMD_OTF_THR    = 8'h4f;    // Over-temperature fault threshold
  localparam logic [7:0]  CMD_OTW_THR    = 8'h51;    // Over-temperature warning threshold
  localparam logic [7:0]  CMD_OVW_THR    = 8'h57;    // Input overvoltage warning threshold
  localparam logic [7:0]  CMD_UVW_THR    = 8'h58;    // Input undervoltage warning threshold
  localparam logic [7:0]  CMD_SUM_BYTE   = 8'h78;    // Summary flags byte
  localparam logic [7:0]  CMD_SUM_WORD   = 8'h79;    // Summary flags word
  localparam logic [7:0]  CMD_INPUT      = 8'h7c;    // Input flags
  localparam logic [7:0]  CMD_TEMP       = 8'h7d;    // Temperature flags
  localparam logic [7:0]  FEATURE_VAL    = 8'hb0;    // Constant feature report
  localparam logic [15:0] OTF_THR_RST    = 16'h0960; // Fault threshold after reset
  localparam logic [15:0] OTW_THR_RST    = 16'h07d0; // Warning threshold after reset
  localparam logic [15:0] OVW_THR_RST    = 16'h0fff; // Overvoltage threshold after reset
  localparam logic [15:0] UVW_THR_RST    = 16'h0000; // Undervoltage threshold after reset
  localparam logic [15:0] THR_HIGH_OFF   = 16'h0fff; // Disables an upper threshold
  localparam logic [15:0] THR_LOW_OFF    = 16'h0000; // Disables a lower threshold
  localparam logic [7:0]  UNMAPPED_VAL   = 8'hff;    // Read data of unknown commands
  localparam int          FLAG_W         = 6;        // Measurement-driven flags
  localparam int          FL_OTF         = 0;        // Over-temperature fault
  localparam int          FL_OTW         = 1;        // Over-temperature warning
  localparam int          FL_OVW         = 2;        // Input overvoltage warning
  localparam int          FL_UVW         = 3;        // Input undervoltage warning
  localparam int          FL_OCW         = 4;        // Input overcurrent warning
  localparam int          FL_OPW         = 5;        // Input overpower warning
  localparam logic        UVF_RST        = 1'b1;     // Input undervolt fault bit at startup
  localparam logic        VSF_RST        = 1'b1;     // Vendor-specific fault bit at startup
  localparam logic        ALERT_RST      = 1'b1;     // Alert driven while startup bits stand
  localparam logic [2:0]  WCNT_CMD_ONLY  = 3'd1;     // Send-byte length
  localparam logic [2:0]  WCNT_WORD      = 3'd3;     // Write-word length
  localparam logic [2:0]  WCNT_MAX       = 3'd7;     // Saturation of byte count
endpackage

// *** shared/pmls_byte_if.sv ***
// Byte-level link between the bus slave and the command bank
`timescale 1ns/100ps
`default_nettype none
interface pmls_byte_if;
  logic       start;    // Start or repeated start seen, pulse
  logic       stop;     // Stop seen, pulse
  logic       rx_valid; // Written byte received and acked, pulse
  logic [7:0] rx_data;  // Received byte
  logic       rd;       // Current address phase was a read, level
  logic       tx_next;  // Host acked a read byte, pulse
  logic [7:0] tx_data;  // Byte the bank offers for the next read slot
  modport slave (output start, stop, rx_valid, rx_data, rd, tx_next, input tx_data);
  modport bank  (input start, stop, rx_valid, rx_data, rd, tx_next, output tx_data);
endinterface
`default_nettype wire

// *** verilog/pmls_sync.sv ***
// Two-stage synchroniser for bus pins
`timescale 1ns/100ps
`default_nettype none
module pmls_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q; // First stage, read only by the second
  // Two flops per bit; idle bus level is high
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q   <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** verilog/pmls_smb_slave.sv ***
// Two-wire bus slave: start/stop detection, address match, byte shifting and acks
`timescale 1ns/100ps
`default_nettype none
module pmls_smb_slave
  import pmls_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  rstn,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  output logic       sda_o,
  output logic       sda_oe,
  pmls_byte_if.slave bus
);
  typedef enum {SL_IDLE, SL_ADDR, SL_AACK, SL_RX, SL_RACK, SL_TX, SL_TACK} pmls_sl_t;
  pmls_sl_t   st_q, st_d;            // Bit-level state
  logic [1:0] pin_s;                 // Synchronised {scl, sda}
  logic       scl_p_q, sda_p_q;      // Previous synchronised levels
  logic [3:0] cnt_q, cnt_d;          // Bits in current byte
  logic [7:0] sh_q, sh_d;            // Shift register
  logic       oe_q, oe_d;            // Pull sda low
  logic       rd_q, rd_d;            // Read direction
  logic       st_p_q, st_p_d, sp_p_q, sp_p_d, rxv_q, rxv_d, txn_q, txn_d;
  logic       scl_r, scl_f, start_e, stop_e;
  pmls_sync #(.WIDTH(2)) u_sync (.core_clk(core_clk), .rstn(rstn), .async_in({scl_i, sda_i}), .sync_out(pin_s));
  assign scl_r   = pin_s[1] & ~scl_p_q;
  assign scl_f   = ~pin_s[1] & scl_p_q;
  assign start_e = pin_s[1] & scl_p_q & sda_p_q & ~pin_s[0];
  assign stop_e  = pin_s[1] & scl_p_q & ~sda_p_q & pin_s[0];
  ////////////////////////////////////////////////////////////////////////////
  // Next state: sample on scl rise, drive on scl fall
  always_comb
  begin
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; oe_d = oe_q; rd_d = rd_q;
    st_p_d = 1'b0; sp_p_d = 1'b0; rxv_d = 1'b0; txn_d = 1'b0;
    if (start_e)
    begin
      st_d = SL_ADDR; cnt_d = 4'h0; oe_d = 1'b0; rd_d = 1'b0; st_p_d = 1'b1;
    end
    else if (stop_e)
    begin
      st_d = SL_IDLE; oe_d = 1'b0; sp_p_d = 1'b1;
    end
    else if (scl_r)
    begin
      case (st_q)
        SL_ADDR, SL_RX: begin sh_d = {sh_q[6:0], pin_s[0]}; cnt_d = cnt_q + 4'h1; end
        SL_TX:          cnt_d = cnt_q + 4'h1;
        SL_TACK:        if (pin_s[0]) st_d = SL_IDLE; else txn_d = 1'b1; // Nack ends read
        default:        ;
      endcase
    end
    else if (scl_f)
    begin
      case (st_q)
        SL_ADDR:
          if (cnt_q == 4'h8)
          begin
            if (sh_q[7:1] == DEV_ADDR) begin st_d = SL_AACK; oe_d = 1'b1; rd_d = sh_q[0]; end
            else st_d = SL_IDLE; // Not our address
          end
        SL_AACK, SL_TACK:
          if (rd_q) begin st_d = SL_TX; cnt_d = 4'h0; sh_d = bus.tx_data; oe_d = ~bus.tx_data[7]; end
          else begin st_d = SL_RX; cnt_d = 4'h0; oe_d = 1'b0; end
        SL_RX:
          if (cnt_q == 4'h8) begin st_d = SL_RACK; oe_d = 1'b1; rxv_d = 1'b1; end
        SL_RACK: begin st_d = SL_RX; cnt_d = 4'h0; oe_d = 1'b0; end
        SL_TX:
          if (cnt_q == 4'h8) begin st_d = SL_TACK; oe_d = 1'b0; end
          else begin oe_d = ~sh_q[6]; sh_d = {sh_q[6:0], 1'b0}; end
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= SL_IDLE; cnt_q <= 4'h0; sh_q <= 8'h00; oe_q <= 1'b0; rd_q <= 1'b0;
      scl_p_q <= 1'b1; sda_p_q <= 1'b1; st_p_q <= 1'b0; sp_p_q <= 1'b0; rxv_q <= 1'b0; txn_q <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; oe_q <= oe_d; rd_q <= rd_d;
      scl_p_q <= pin_s[1]; sda_p_q <= pin_s[0]; st_p_q <= st_p_d; sp_p_q <= sp_p_d;
      rxv_q <= rxv_d; txn_q <= txn_d;
      sda_o <= 1'b0; // Open drain: only ever pulls low
    end
  end
  assign sda_oe       = oe_q;
  assign bus.start    = st_p_q;
  assign bus.stop     = sp_p_q;
  assign bus.rx_valid = rxv_q;
  assign bus.rx_data  = sh_q;
  assign bus.rd       = rd_q;
  assign bus.tx_next  = txn_q;
endmodule
`default_nettype wire

// *** verilog/pmls_top.sv ***
// Command-addressed limit and status bank with alert output
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1 - Clear command resets flags and releases alert
// R2 - Present condition keeps flag, alert stays
// R3 - Feature report reads constant b0
// R4 - Temperature above fault threshold sets fault
// R5 - Fault threshold 0fff disables, reset 0960
// R6 - Temperature above warning threshold sets warning
// R7 - Warning threshold 0fff disables, reset 07d0
// R8 - Input above overvoltage threshold sets warning
// R9 - Overvoltage threshold 0fff disables detection
// R10 - Input below undervoltage threshold sets warning
// R11 - Undervoltage threshold zero disables, reset zero
// R12 - Host uses word transfers for thresholds
// R13 - Summary byte layout, bits 7-4 zero
// R14 - Flags latched until condition gone, cleared
// R15 - Summary word mirrors byte, bits 13,12
// R16 - Input and undervolt bits set at startup
// R17 - Input flags bits 6,5; bit 7 zero
// R18 - Input flags bits 1,0; bits 4-2 zero
// R19 - Temperature flags bits 7,6 only
// R20 - Compare on every new measurement sample
// R21 - Alert held while any flag latched
module pmls_top
  import pmls_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             alert_line_oe,
  input  wire logic [11:0] temp_meas,
  input  wire logic [11:0] supply_input_voltage,
  input  wire logic        meas_valid,
  input  wire logic        overcurrent_cond,
  input  wire logic        overpower_cond
);
  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // Word-wide threshold commands
  function automatic logic is_thr(input logic [7:0] c);
    is_thr = (c == CMD_OTF_THR) || (c == CMD_OTW_THR) || (c == CMD_OVW_THR) || (c == CMD_UVW_THR);
  endfunction
  // Any command this bank answers
  function automatic logic is_known(input logic [7:0] c);
    is_known = is_thr(c) || (c == CMD_CLEAR) || (c == CMD_FEATURE) || (c == CMD_SUM_BYTE)
               || (c == CMD_SUM_WORD) || (c == CMD_INPUT) || (c == CMD_TEMP);
  endfunction
  // Upper limit crossing with its disable code
  function automatic logic above(input logic [11:0] m, input logic [15:0] t);
    above = (t != THR_HIGH_OFF) && ({4'h0, m} > t);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  pmls_byte_if bus ();                       // Link to the bus slave
  logic [7:0]        cmd_q, cmd_d;           // Latched command code
  logic [2:0]        wcnt_q, wcnt_d;         // Bytes written since start
  logic [7:0]        wb1_q, wb1_d;           // First data byte (low)
  logic [7:0]        wb2_q, wb2_d;           // Second data byte (high)
  logic              ptr_q, ptr_d;           // Read byte pointer
  logic              past_q, past_d;         // Read ran past the data
  logic [7:0]        tx_q, tx_d;             // Offered read byte
  logic [15:0]       otf_thr_q, otf_thr_d;   // Over-temperature fault threshold
  logic [15:0]       otw_thr_q, otw_thr_d;   // Over-temperature warning threshold
  logic [15:0]       ovw_thr_q, ovw_thr_d;   // Overvoltage warning threshold
  logic [15:0]       uvw_thr_q, uvw_thr_d;   // Undervoltage warning threshold
  logic [FLAG_W-1:0] flag_q, flag_d;         // Latched measurement flags
  logic [FLAG_W-1:0] cond_q, cond_d;         // Condition seen at the last sample
  logic [FLAG_W-1:0] cond_now;               // Condition of the current sample
  logic              comm_fault_q, comm_fault_d;      // Communication fault
  logic              uv_fault_q, uv_fault_d;          // Input undervolt fault bit
  logic              vendor_fault_q, vendor_fault_d;  // Vendor-specific fault bit
  logic              alert_q, alert_d;       // Alert pull-down
  logic              clr;                    // Clear command executes
  logic              wr_exec;                // Write-word executes
  logic              comm_set;               // Bad transaction seen
  logic [7:0]        sum_byte;               // Summary flags byte
  logic [15:0]       sum_word;               // Summary flags word
  logic [7:0]        in_byte;                // Input flags byte
  logic [7:0]        tmp_byte;               // Temperature flags byte
  logic [15:0]       rd_word;                // Word selected by the command

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  pmls_smb_slave u_slave (
    .core_clk (core_clk),
    .rstn     (rstn),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .bus      (bus)
  );
  assign bus.tx_data = tx_q;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction tracking and command execution at stop
  always_comb
  begin
    cmd_d    = cmd_q;
    wcnt_d   = wcnt_q;
    wb1_d    = wb1_q;
    wb2_d    = wb2_q;
    clr      = 1'b0;
    wr_exec  = 1'b0;
    comm_set = 1'b0;
    // Start or repeated start: count anew, command kept
    if (bus.start)
      wcnt_d = 3'd0;
    else if (bus.rx_valid)
    begin
      // Saturating byte count
      if (wcnt_q != WCNT_MAX)
        wcnt_d = wcnt_q + 3'd1;
      case (wcnt_q)
        3'd0:    cmd_d = bus.rx_data;
        3'd1:    wb1_d = bus.rx_data;
        3'd2:    wb2_d = bus.rx_data;
        default: ;
      endcase
    end
    // Stop ends a transaction
    if (bus.stop)
    begin
      if (bus.rd)
        comm_set = !is_known(cmd_q) || (cmd_q == CMD_CLEAR) || past_q;
      else if (wcnt_q == WCNT_CMD_ONLY && cmd_q == CMD_CLEAR)
        clr = 1'b1; // R1
      else if (wcnt_q == WCNT_WORD && is_thr(cmd_q))
        wr_exec = 1'b1; // R12
      else if (wcnt_q != 3'd0 && !(wcnt_q == WCNT_CMD_ONLY && is_known(cmd_q)))
        comm_set = 1'b1; // Wrong length or unknown command
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold registers
  always_comb
  begin
    otf_thr_d = otf_thr_q;
    otw_thr_d = otw_thr_q;
    ovw_thr_d = ovw_thr_q;
    uvw_thr_d = uvw_thr_q;
    if (wr_exec)
    begin
      // Low byte first on the wire
      case (cmd_q)
        CMD_OTF_THR: otf_thr_d = {wb2_q, wb1_q}; // R4
        CMD_OTW_THR: otw_thr_d = {wb2_q, wb1_q}; // R6
        CMD_OVW_THR: ovw_thr_d = {wb2_q, wb1_q}; // R8
        CMD_UVW_THR: uvw_thr_d = {wb2_q, wb1_q}; // R10
        default:     ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparisons on each sample
  always_comb
  begin
    cond_now         = '0;
    cond_now[FL_OTF] = above(temp_meas, otf_thr_q); // R4 R5
    cond_now[FL_OTW] = above(temp_meas, otw_thr_q); // R6 R7
    cond_now[FL_OVW] = above(supply_input_voltage, ovw_thr_q); // R8 R9
    cond_now[FL_UVW] = (uvw_thr_q != THR_LOW_OFF) && ({4'h0, supply_input_voltage} < uvw_thr_q); // R10 R11
    cond_now[FL_OCW] = overcurrent_cond; // R18
    cond_now[FL_OPW] = overpower_cond; // R18
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a set or a standing condition wins over a clear
  always_comb
  begin
    cond_d = meas_valid ? cond_now : cond_q; // R20
    flag_d = (flag_q & ~{FLAG_W{clr}}) // R14
             | (meas_valid ? cond_now : '0) // R20
             | (clr ? cond_q : '0); // R2
    comm_fault_d   = (comm_fault_q & ~clr) | comm_set;
    uv_fault_d     = uv_fault_q & ~clr; // R16
    vendor_fault_d = vendor_fault_q & ~clr; // R15
    alert_d = (|flag_d) | comm_fault_d | uv_fault_d | vendor_fault_d; // R21
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status views
  always_comb
  begin
    // Summary byte
    sum_byte = {4'h0, uv_fault_q, flag_q[FL_OTF] | flag_q[FL_OTW], comm_fault_q,
                flag_q[FL_OVW] | flag_q[FL_UVW] | flag_q[FL_OCW] | flag_q[FL_OPW] | vendor_fault_q}; // R13
    // Summary word: input summary, vendor bit, mirrored low byte
    sum_word = {2'b00, uv_fault_q | flag_q[FL_OVW] | flag_q[FL_UVW] | flag_q[FL_OCW] | flag_q[FL_OPW],
                vendor_fault_q, 4'h0, sum_byte}; // R15 R16
    // Input flags
    in_byte  = {1'b0, flag_q[FL_OVW], flag_q[FL_UVW], 3'b000, flag_q[FL_OCW], flag_q[FL_OPW]}; // R17 R18
    // Temperature flags
    tmp_byte = {flag_q[FL_OTF], flag_q[FL_OTW], 6'h00}; // R19
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: pointer and offered byte
  always_comb
  begin
    ptr_d  = ptr_q;
    past_d = past_q;
    if (bus.start)
    begin
      ptr_d  = 1'b0;
      past_d = 1'b0;
    end
    else if (bus.tx_next)
    begin
      past_d = past_q | ptr_q;
      ptr_d  = 1'b1;
    end
    // Word selected by command
    case (cmd_q)
      CMD_FEATURE:  rd_word = {8'h00, FEATURE_VAL}; // R3
      CMD_OTF_THR:  rd_word = otf_thr_q;
      CMD_OTW_THR:  rd_word = otw_thr_q;
      CMD_OVW_THR:  rd_word = ovw_thr_q;
      CMD_UVW_THR:  rd_word = uvw_thr_q;
      CMD_SUM_BYTE: rd_word = {8'h00, sum_byte};
      CMD_SUM_WORD: rd_word = sum_word;
      CMD_INPUT:    rd_word = {8'h00, in_byte};
      CMD_TEMP:     rd_word = {8'h00, tmp_byte};
      default:      rd_word = {UNMAPPED_VAL, UNMAPPED_VAL};
    endcase
    // Low byte first, then high, then filler
    if (past_d)
      tx_d = UNMAPPED_VAL;
    else if (ptr_d)
      tx_d = rd_word[15:8];
    else
      tx_d = rd_word[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_q          <= 8'h00;
      wcnt_q         <= 3'd0;
      wb1_q          <= 8'h00;
      wb2_q          <= 8'h00;
      ptr_q          <= 1'b0;
      past_q         <= 1'b0;
      tx_q           <= 8'h00;
      otf_thr_q      <= OTF_THR_RST; // R5
      otw_thr_q      <= OTW_THR_RST; // R7
      ovw_thr_q      <= OVW_THR_RST; // R9
      uvw_thr_q      <= UVW_THR_RST; // R11
      flag_q         <= '0;
      cond_q         <= '0;
      comm_fault_q   <= 1'b0;
      uv_fault_q     <= UVF_RST; // R16
      vendor_fault_q <= VSF_RST; // R15
      alert_q        <= ALERT_RST;
    end
    else
    begin
      cmd_q          <= cmd_d;
      wcnt_q         <= wcnt_d;
      wb1_q          <= wb1_d;
      wb2_q          <= wb2_d;
      ptr_q          <= ptr_d;
      past_q         <= past_d;
      tx_q           <= tx_d;
      otf_thr_q      <= otf_thr_d;
      otw_thr_q      <= otw_thr_d;
      ovw_thr_q      <= ovw_thr_d;
      uvw_thr_q      <= uvw_thr_d;
      flag_q         <= flag_d;
      cond_q         <= cond_d;
      comm_fault_q   <= comm_fault_d;
      uv_fault_q     <= uv_fault_d;
      vendor_fault_q <= vendor_fault_d;
      alert_q        <= alert_d;
    end
  end
  assign alert_line_oe = alert_q; // R21
endmodule
`default_nettype wire

// *** bench/pmls_host_model.sv ***
// Host-side model of the two-wire bus: start, stop and nine-bit slots
`timescale 1ns/100ps
`default_nettype none
module pmls_host_model (
  input  wire logic core_clk,
  input  wire logic sda_o,
  input  wire logic sda_oe,
  output logic      scl_i,
  output logic      sda_i
);
  logic host_pull;  // High while the host pulls data low
  initial
  begin
    scl_i     = 1'b1;
    host_pull = 1'b0;
  end
  // Open-drain data wire with pull-up, both parties may pull
  assign sda_i = !host_pull && (sda_oe ? sda_o : 1'b1);
  // Wait n core cycles, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Start or repeated start, data falls while clock high
  task automatic start();
    host_pull = 1'b0;
    tick(5);
    scl_i = 1'b1;
    tick(5);
    host_pull = 1'b1;
    tick(5);
    scl_i = 1'b0;
    tick(5);
  endtask
  // Stop, data rises while clock high, then bus free time
  task automatic stop();
    host_pull = 1'b1;
    tick(5);
    scl_i = 1'b1;
    tick(5);
    host_pull = 1'b0;
    tick(15);
  endtask
  // Nine bits msb first; a one releases the line so the device may answer
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      host_pull = !tx[i];
      tick(5);
      scl_i = 1'b1;
      tick(10);
      rx[i] = sda_i;
      scl_i = 1'b0;
      tick(5);
    end
  endtask
endmodule
`default_nettype wire

// *** bench/pmls_top_props.sv ***
// Port-level checks of the limit and status bank
`timescale 1ns/100ps
`default_nettype none
module pmls_top_props (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        alert_line_oe,
  input wire logic [11:0] temp_meas,
  input wire logic [11:0] supply_input_voltage,
  input wire logic        meas_valid,
  input wire logic        overcurrent_cond,
  input wire logic        overpower_cond
);
  logic       sda_p_q;     // Data level one cycle back
  logic [4:0] stop_age_q;  // Cycles since a stop, saturating
  logic [4:0] stop_age_d;
  // Stop restarts the age count
  always_comb
  begin
    stop_age_d = (stop_age_q == 5'd31) ? stop_age_q : stop_age_q + 5'd1;
    if (scl_i && sda_i && !sda_p_q)
      stop_age_d = 5'd0;
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sda_p_q    <= 1'b1;
      stop_age_q <= 5'd31;
    end
    else
    begin
      sda_p_q    <= sda_i;
      stop_age_q <= stop_age_d;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_startup; $rose(rstn) |-> alert_line_oe; endproperty
  a_startup: assert property (p_startup) else $error("alert low after reset");
  property p_oc_alert; meas_valid && overcurrent_cond |-> ##[1:2] alert_line_oe; endproperty
  a_oc_alert: assert property (p_oc_alert) else $error("no alert after overcurrent");
  property p_op_alert; meas_valid && overpower_cond |-> ##[1:2] alert_line_oe; endproperty
  a_op_alert: assert property (p_op_alert) else $error("no alert after overpower");
  property p_hold; (meas_valid && overcurrent_cond) ##1 !meas_valid [*8] |-> alert_line_oe; endproperty
  a_hold: assert property (p_hold) else $error("alert dropped with condition standing");
  property p_rise; $rose(alert_line_oe) |-> $past(meas_valid) || $past(meas_valid, 2) || stop_age_q < 5'd16;
  endproperty
  a_rise: assert property (p_rise) else $error("alert rose without cause");
  property p_fall; $fell(alert_line_oe) |-> stop_age_q < 5'd12; endproperty
  a_fall: assert property (p_fall) else $error("alert fell without a clear");
  property p_idle; alert_line_oe && stop_age_q > 5'd12 |=> alert_line_oe; endproperty
  a_idle: assert property (p_idle) else $error("latched alert lost");
  property p_sda; scl_i && $past(scl_i) |-> $stable(sda_oe); endproperty
  a_sda: assert property (p_sda) else $error("data moved while clock high");
endmodule
bind pmls_top pmls_top_props u_props (.core_clk, .rstn, .scl_i, .sda_i, .sda_o, .sda_oe, .alert_line_oe,
  .temp_meas, .supply_input_voltage, .meas_valid, .overcurrent_cond, .overpower_cond);
`default_nettype wire

// *** bench/pmls_top_bench.sv ***
// Self-checking bench for the limit and status bank
`timescale 1ns/100ps
`default_nettype none
module pmls_top_bench
  import pmls_pkg::*;
();
  logic        core_clk, rstn, scl_i, sda_i, sda_o, sda_oe, alert_line_oe;
  logic        meas_valid, overcurrent_cond, overpower_cond;
  logic [11:0] temp_meas, supply_input_voltage;
  int          n_mismatch, checked;
  // Reset readback table and threshold sets
  localparam logic [7:0]  RD_CMD [8] = '{8'h19, 8'h4f, 8'h51, 8'h57, 8'h58, 8'h78, 8'h79, 8'h7c};
  localparam logic [15:0] RD_EXP [8] = '{16'h00b0, 16'h0960, 16'h07d0, 16'h0fff, 16'h0, 16'h9, 16'h3009, 16'h0};
  localparam logic [7:0]  THR [4] = '{CMD_OTF_THR, CMD_OTW_THR, CMD_OVW_THR, CMD_UVW_THR};
  localparam logic [15:0] LIM [4] = '{16'h0800, 16'h0700, 16'h0a00, 16'h0200};
  localparam logic [15:0] OFF [4] = '{16'h0fff, 16'h0fff, 16'h0fff, 16'h0000};
  pmls_top dut (.core_clk, .rstn, .scl_i, .sda_i, .sda_o, .sda_oe, .alert_line_oe,
    .temp_meas, .supply_input_voltage, .meas_valid, .overcurrent_cond, .overpower_cond);
  pmls_host_model host (.core_clk, .sda_o, .sda_oe, .scl_i, .sda_i);
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = !core_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Command then nb data bytes, low byte first
  task automatic wr(input logic [7:0] cmd, input int nb, input logic [15:0] v);
    logic [8:0] r;
    host.start();
    host.xfer({DEV_ADDR, 2'b01}, r);
    host.xfer({cmd, 1'b1}, r);
    for (int i = 0; i < nb; i++)
      host.xfer({v[i*8 +: 8], 1'b1}, r);
    host.stop();
    host.tick(8);
  endtask
  // Two-byte read with repeated start, compared to exp
  task automatic rc(input logic [7:0] cmd, input logic [15:0] exp);
    logic [8:0]  r;
    logic [15:0] v;
    host.start();
    host.xfer({DEV_ADDR, 2'b01}, r);
    chk({15'h0, r[0]}, 16'h0000);
    host.xfer({cmd, 1'b1}, r);
    host.start();
    host.xfer({DEV_ADDR, 2'b11}, r);
    host.xfer(9'h1fe, r);
    v[7:0] = r[8:1];
    host.xfer(9'h1ff, r);
    v[15:8] = r[8:1];
    host.stop();
    chk(v, exp);
  endtask
  // One sample pulse on all measurement inputs
  task automatic meas(input logic [11:0] t, input logic [11:0] v, input logic c, input logic p);
    temp_meas            = t;
    supply_input_voltage = v;
    overcurrent_cond     = c;
    overpower_cond       = p;
    meas_valid           = 1'b1;
    host.tick(1);
    meas_valid = 1'b0;
    host.tick(3);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    #300000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    n_mismatch = 0;
    checked = 0;
    rstn = 1'b0;
    meas_valid = 1'b0;
    temp_meas = 12'h000;
    supply_input_voltage = 12'h000;
    overcurrent_cond = 1'b0;
    overpower_cond = 1'b0;
    host.tick(16);
    rstn = 1'b1;
    host.tick(6);
    chk({15'h0, alert_line_oe}, 16'h0001);
    foreach (RD_CMD[i]) rc(RD_CMD[i], RD_EXP[i]);
    wr(CMD_CLEAR, 0, 16'h0000);
    chk({15'h0, alert_line_oe}, 16'h0000);
    rc(CMD_SUM_WORD, 16'h0000);
    foreach (THR[i]) wr(THR[i], 2, LIM[i]);
    foreach (THR[i]) rc(THR[i], LIM[i]);
    meas(12'h700, 12'h200, 1'b0, 1'b0);
    chk({15'h0, alert_line_oe}, 16'h0000);
    meas(12'h701, 12'h200, 1'b0, 1'b0);
    chk({15'h0, alert_line_oe}, 16'h0001);
    rc(CMD_TEMP, 16'h0040);
    rc(CMD_SUM_BYTE, 16'h0004);
    meas(12'h801, 12'h200, 1'b0, 1'b0);
    wr(CMD_CLEAR, 0, 16'h0000);
    chk({15'h0, alert_line_oe}, 16'h0001);
    rc(CMD_TEMP, 16'h00c0);
    meas(12'h000, 12'h300, 1'b0, 1'b0);
    wr(CMD_CLEAR, 0, 16'h0000);
    chk({15'h0, alert_line_oe}, 16'h0000);
    rc(CMD_TEMP, 16'h0000);
    meas(12'h000, 12'ha01, 1'b0, 1'b0);
    rc(CMD_INPUT, 16'h0040);
    rc(CMD_SUM_WORD, 16'h2001);
    meas(12'h000, 12'h1ff, 1'b1, 1'b1);
    rc(CMD_INPUT, 16'h0063);
    meas(12'h000, 12'h300, 1'b0, 1'b0);
    wr(CMD_CLEAR, 0, 16'h0000);
    chk({15'h0, alert_line_oe}, 16'h0000);
    foreach (THR[i]) wr(THR[i], 2, OFF[i]);
    meas(12'hfff, 12'hfff, 1'b0, 1'b0);
    meas(12'hfff, 12'h000, 1'b0, 1'b0);
    chk({15'h0, alert_line_oe}, 16'h0000);
    wr(CMD_OVW_THR, 1, 16'h0012);
    rc(CMD_OVW_THR, 16'h0fff);
    rc(8'h88, {UNMAPPED_VAL, UNMAPPED_VAL});
    rc(CMD_SUM_BYTE, 16'h0002);
    close_out();
  end
endmodule
`default_nettype wire
